// file: bench/acpc_host_model.sv
// Host model driving trigger, power-down and I/O select pins
`default_nettype none
module acpc_host_model (
   // Clock
   input wire logic clock,
   // Pins toward the converter
   output logic conv_trigger,
   output logic power_down_in,
   output logic io_sel_diff
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      conv_trigger = 1'b0;
      power_down_in = 1'b0;
      io_sel_diff = 1'b0;
   end
   // Rising edge, high two cycles, then low
   task automatic convert();
      @(posedge clock);
      conv_trigger <= 1'b1;
      repeat (2) @(posedge clock);
      conv_trigger <= 1'b0;
   endtask
   task automatic set_pd(input logic v);
      @(posedge clock);
      power_down_in <= v;
   endtask
   task automatic set_io(input logic v);
      @(posedge clock);
      io_sel_diff <= v;
   endtask
endmodule
`default_nettype wire

// file: bench/test_adc_conversion_power_control.sv
// Self-checking bench for the conversion and power-down control
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_adc_conversion_power_control;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic bus_select_n = 1'b1;
   logic [7:0] ch_enable = 8'h01;
   logic conv_trigger, power_down_in, io_sel_diff;
   logic busy, hold, powered_down, diff_io_mode, global_reset;
   logic [31:0] rng = 32'h581487dd;
   logic [7:0] exp_q[$];
   logic [7:0] len = 8'h00;
   logic [7:0] exp_len;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;
   always #25 clock = ~clock;
   acpc_ctrl dut (.clock(clock), .srst(srst), .conv_trigger(conv_trigger),
      .power_down_in(power_down_in), .io_sel_diff(io_sel_diff),
      .bus_select_n(bus_select_n), .ch_enable(ch_enable), .busy(busy), .hold(hold),
      .powered_down(powered_down), .diff_io_mode(diff_io_mode),
      .global_reset(global_reset));
   acpc_host_model host (.clock(clock), .conv_trigger(conv_trigger),
      .power_down_in(power_down_in), .io_sel_diff(io_sel_diff));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   // Measure each busy pulse against the oldest note
   always @(posedge clock) begin
      #1;
      if (busy === 1'b1) begin
         len = len + 8'h01;
         `CHK("hold", 1'b1, hold)
      end else if (len != 8'h00) begin
         `CHK("hold low", 1'b0, hold)
         exp_len = (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00;
         `CHK("busy length", exp_len, len)
         len = 8'h00;
      end
   end
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic wait_idle();
      int i;
      i = 0;
      while (busy !== 1'b0 && i < 200) begin
         tick(1);
         i++;
      end
   endtask
   task automatic note_conv(input logic [7:0] en);
      int c;
      c = $countones(en);
      exp_q.push_back(8'(10 * ((c == 0) ? 1 : c)));
   endtask
   initial begin
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      for (int k = 0; k < 6; k++) begin
         rng = xorshift(rng);
         @(posedge clock);
         ch_enable <= rng[7:0];
         bus_select_n <= rng[8];
         host.set_io(rng[9]);
         note_conv(rng[7:0]);
         host.convert();
         // Second edge lands while busy
         if (k == 0) host.convert();
         wait_idle();
         `CHK("io mode", rng[9], diff_io_mode)
      end
      note_conv(ch_enable);
      host.convert();
      host.set_pd(1'b1);
      tick(2);
      `CHK("sleep early", 1'b0, powered_down)
      wait_idle();
      `CHK("sleep after", 1'b1, powered_down)
      host.convert();
      tick(12);
      `CHK("busy asleep", 1'b0, busy)
      host.set_pd(1'b0);
      tick(3);
      `CHK("awake", 1'b0, powered_down)
      note_conv(ch_enable);
      host.convert();
      wait_idle();
      host.set_pd(1'b1);
      tick(1);
      `CHK("sleep", 1'b1, powered_down)
      tick(8);
      `CHK("no reset", 1'b0, global_reset)
      host.set_pd(1'b0);
      tick(3);
      host.set_pd(1'b1);
      n = 0;
      for (int i = 0; i < 12; i++) begin
         tick(1);
         if (global_reset === 1'b1) n++;
      end
      `CHK("reset pulse", 4, n)
      print_verdict();
   end
endmodule
`default_nettype wire

// file: design/acpc_conv_timer.sv
// Conversion timer: counts 500 ns per enabled channel
`include "acpc_params.svh"
`default_nettype none
module acpc_conv_timer
   import acpc_pkg::*;
#(
   parameter int CH_CYCLES = `ACPC_CH_CYCLES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Control side
   acpc_timer_if.timer tif
);
   logic [7:0] cnt_reg, cnt_next;
   logic done_reg, done_next;
   localparam logic [7:0] CH_CYC = 8'(CH_CYCLES);
   // Start and done each cost one register stage
   localparam logic [7:0] LAT = 8'(`ACPC_TIMER_LAT);

   always_comb begin
      cnt_next = cnt_reg;
      done_next = 1'b0;
      if (tif.start) begin
         cnt_next = 8'(tif.nch * CH_CYC) - LAT;
      end else if (cnt_reg != 8'h00) begin
         cnt_next = cnt_reg - 8'h01;
         done_next = (cnt_reg == 8'h01);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_reg <= 8'h00;
         done_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign tif.done = done_reg;
endmodule
`default_nettype wire

// file: design/acpc_ctrl.sv
// Conversion trigger, busy and power-down control
`include "acpc_params.svh"
`default_nettype none
module acpc_ctrl
   import acpc_pkg::*;
#(
   parameter int NUM_CH = `ACPC_NUM_CH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic srst,
   // Host pins
   input wire logic conv_trigger,
   input wire logic power_down_in,
   input wire logic io_sel_diff,
   input wire logic bus_select_n,
   // Channel enables, one bit per channel
   input wire logic [NUM_CH-1:0] ch_enable,
   // Status outputs
   output logic busy,
   output logic hold,
   output logic powered_down,
   output logic diff_io_mode,
   output logic global_reset
);
   acpc_timer_if tif ();
   acpc_conv_timer u_timer (
      .clock(clock),
      .srst(srst),
      .tif(tif)
   );

   acpc_state_t state_reg, state_next;
   logic trig_d_reg, trig_d_next;
   logic pd_d_reg, pd_d_next;
   logic pd_armed_reg, pd_armed_next;
   logic pd_pend_reg, pd_pend_next;
   logic [2:0] grst_reg, grst_next;
   logic busy_reg, busy_next;
   logic hold_reg, hold_next;
   logic pdn_reg, pdn_next;
   logic io_reg, io_next;
   logic grst_out_reg, grst_out_next;
   logic start_next, start_reg;
   logic [3:0] nch_reg, nch_next;
   logic trig_rise, pd_rise;
   logic [7:0] busy_len_reg, busy_len_next;
   localparam logic [7:0] CH_CYC = 8'(`ACPC_CH_CYCLES);

   function automatic logic [3:0] count_ones(input logic [NUM_CH-1:0] v);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < NUM_CH; i++) begin
         c = c + 4'(v[i]);
      end
      return c;
   endfunction

   assign trig_rise = conv_trigger & ~trig_d_reg;
   assign pd_rise = power_down_in & ~pd_d_reg;
   assign tif.start = start_reg;
   assign tif.nch = nch_reg;

   always_comb begin
      state_next = state_reg;
      trig_d_next = conv_trigger;
      pd_d_next = power_down_in;
      pd_armed_next = pd_armed_reg;
      pd_pend_next = pd_pend_reg | pd_rise;
      grst_next = (grst_reg != 3'h0) ? grst_reg - 3'h1 : 3'h0;
      busy_next = busy_reg;
      hold_next = hold_reg;
      start_next = 1'b0;
      nch_next = nch_reg;
      io_next = io_sel_diff;
      if (pd_rise) begin
         if (pd_armed_reg) begin
            grst_next = 3'(`ACPC_GRST_CYCLES);
            pd_armed_next = 1'b0;
         end else begin
            pd_armed_next = 1'b1;
         end
      end
      case (state_reg)
         ACPC_IDLE: begin
            pd_pend_next = 1'b0;
            if (power_down_in) begin
               state_next = ACPC_SLEEP;
            end else if (trig_rise) begin
               // start on edge, bus select ignored
               state_next = ACPC_CONV;
               busy_next = 1'b1;
               hold_next = 1'b1;
               start_next = 1'b1;
               nch_next = (count_ones(ch_enable) == 4'h0) ? 4'h1 : count_ones(ch_enable);
               pd_armed_next = 1'b0;
            end
         end
         ACPC_CONV: begin
            if (tif.done) begin
               busy_next = 1'b0;
               hold_next = 1'b0;
               state_next = (power_down_in | pd_pend_reg) ? ACPC_SLEEP : ACPC_IDLE;
               pd_pend_next = 1'b0;
            end
         end
         ACPC_SLEEP: begin
            if (!power_down_in) begin
               state_next = ACPC_IDLE;
            end
         end
         default: state_next = ACPC_IDLE;
      endcase
      pdn_next = (state_next == ACPC_SLEEP);
      grst_out_next = (grst_next != 3'h0);
      if (grst_reg != 3'h0) begin
         state_next = power_down_in ? ACPC_SLEEP : ACPC_IDLE;
         busy_next = 1'b0;
         hold_next = 1'b0;
         start_next = 1'b0;
         pd_pend_next = 1'b0;
         pdn_next = power_down_in;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= ACPC_IDLE;
         trig_d_reg <= 1'b0;
         pd_d_reg <= 1'b0;
         pd_armed_reg <= 1'b0;
         pd_pend_reg <= 1'b0;
         grst_reg <= 3'h0;
         busy_reg <= 1'b0;
         hold_reg <= 1'b0;
         pdn_reg <= 1'b0;
         io_reg <= 1'b0;
         grst_out_reg <= 1'b0;
         start_reg <= 1'b0;
         nch_reg <= 4'h1;
      end else begin
         state_reg <= state_next;
         trig_d_reg <= trig_d_next;
         pd_d_reg <= pd_d_next;
         pd_armed_reg <= pd_armed_next;
         pd_pend_reg <= pd_pend_next;
         grst_reg <= grst_next;
         busy_reg <= busy_next;
         hold_reg <= hold_next;
         pdn_reg <= pdn_next;
         io_reg <= io_next;
         grst_out_reg <= grst_out_next;
         start_reg <= start_next;
         nch_reg <= nch_next;
      end
   end

   assign busy = busy_reg;
   assign hold = hold_reg;
   assign powered_down = pdn_reg;
   assign diff_io_mode = io_reg;
   assign global_reset = grst_out_reg;

   always_comb begin
      busy_len_next = busy_reg ? busy_len_reg + 8'h01 : 8'h00;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         busy_len_reg <= 8'h00;
      end else begin
         busy_len_reg <= busy_len_next;
      end
   end

   AST_BUSY_RISE: assert property (@(posedge clock) disable iff (srst)
      state_reg == ACPC_IDLE && !power_down_in && trig_rise && grst_reg == 3'h0
      |=> busy && hold && start_reg)
      else $error("busy did not rise on trigger");

   AST_SLEEP_IGNORE: assert property (@(posedge clock) disable iff (srst)
      power_down_in |=> !$rose(busy))
      else $error("trigger accepted while powered down");

   AST_BUSY_HELD: assert property (@(posedge clock) disable iff (srst)
      $rose(busy) |-> busy [*8])
      else $error("busy dropped early");

   AST_CONV_LEN: assert property (@(posedge clock) disable iff (srst)
      $fell(busy) && $past(grst_reg) == 3'h0 |-> busy_len_reg == 8'(nch_reg * CH_CYC))
      else $error("conversion length not 500 ns per channel");

   AST_PD_AFTER: assert property (@(posedge clock) disable iff (srst)
      busy && power_down_in |=> busy || powered_down || global_reset)
      else $error("power down cut conversion");

   AST_NO_EARLY_SLEEP: assert property (@(posedge clock) disable iff (srst)
      busy |-> !powered_down)
      else $error("powered down during conversion");

   AST_WAKE: assert property (@(posedge clock) disable iff (srst)
      state_reg == ACPC_SLEEP && !power_down_in |=> state_reg == ACPC_IDLE)
      else $error("no wake after power down low");

   AST_IO_SEL: assert property (@(posedge clock) disable iff (srst)
      1'b1 |=> diff_io_mode == $past(io_sel_diff))
      else $error("io mode not followed");

   AST_GRST: assert property (@(posedge clock) disable iff (srst)
      pd_rise && pd_armed_reg |=> ##1 global_reset)
      else $error("double power down gave no reset");

   AST_NO_GRST: assert property (@(posedge clock) disable iff (srst)
      pd_rise && !pd_armed_reg && grst_reg == 3'h0 |=> !global_reset)
      else $error("single power down gave a reset");

   AST_GRST_LEN: assert property (@(posedge clock) disable iff (srst)
      $rose(global_reset) |-> global_reset [*4] ##1 !global_reset)
      else $error("global reset pulse length wrong");
endmodule
`default_nettype wire

// file: design/acpc_params.svh
// Constants for the conversion and power-down control block
// Behaviour
// - Trigger rising edge puts all sample-holds into hold and starts a conversion
// - Trigger acts whatever the state of the serial bus select
// - Busy rises at conversion start and stays high until it ends
// - While power-down is high the device sleeps and ignores triggers
// - Power-down during a conversion takes effect after that conversion completes
// - Two power-down pulses with no conversion between cause a global reset
// - I/O-standard select high picks differential interface, low single-ended
// - All eight channels sampled at one instant, each digitized per conversion; the code times only the enabled channels, at least one
// - Conversion time is 500 ns per enabled channel
`ifndef ACPC_PARAMS_SVH
`define ACPC_PARAMS_SVH
`define ACPC_CLK_NS 50
`define ACPC_CONV_PER_CH_NS 500
`define ACPC_NUM_CH 8
`define ACPC_GRST_CYCLES 4
`define ACPC_CH_CYCLES ((`ACPC_CONV_PER_CH_NS + `ACPC_CLK_NS - 1) / `ACPC_CLK_NS)
`define ACPC_TIMER_LAT 2
`endif

// file: design/acpc_pkg.sv
// Types for the conversion and power-down control block
`default_nettype none
package acpc_pkg;
   typedef enum logic [1:0] {ACPC_IDLE, ACPC_CONV, ACPC_SLEEP} acpc_state_t;
endpackage
`default_nettype wire

// file: design/acpc_timer_if.sv
// Handshake between control FSM and conversion timer
`default_nettype none
interface acpc_timer_if;
   logic start;
   logic [3:0] nch;
   logic done;
   modport ctrl (output start, output nch, input done);
   modport timer (input start, input nch, output done);
endinterface
`default_nettype wire
